// ==== core/prsc_ctrl.sv ====
// Run/stop arbitration, output gating and fixed scan supervision
//
// Behaviour
// - Hold flag keeps run outputs after stop
// - Inhibit flag forces all outputs off
// - Run pin pulse enters run mode
// - Stop pin pulse enters stop mode
// - Run input selectable among all sixteen points
// - Run input choice applies after power-up only
// - Simultaneous run and stop: stop wins
// - Mode switch to run while stopped runs
// - Stop command overrides mode switch run position
// - Forced run mode plus request enters run
// - Forced stop request during forced run stops
// - Switch at run still honours remote stops
// - Tool run/stop commands switch the mode
// - Fixed scan: scan lasts at least set ms
// - Early finish idles then restarts step zero
// - Scan time display includes idle padding
// - Step inhibit blocks step state transfer
// - Active step outputs keep working when inhibited
`timescale 1ns/1ps
module prsc_ctrl
  import prsc_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [NUM_POINTS-1:0] input_points,
  input wire logic stop_switch_pin,
  input wire logic mode_switch_run_pin,
  input wire logic [SEL_W-1:0] run_input_sel_cfg,
  input wire logic tool_run_cmd,
  input wire logic tool_stop_cmd,
  input wire logic forced_run_mode_flag,
  input wire logic forced_run_request_flag,
  input wire logic forced_stop_request_flag,
  input wire logic output_hold_on_stop_flag,
  input wire logic global_output_inhibit_flag,
  input wire logic fixed_scan_enable_flag,
  input wire logic [SCAN_W-1:0] fixed_scan_time_register,
  input wire logic step_transfer_inhibit_flag,
  input wire logic step_transfer_req,
  input wire logic scan_done,
  input wire logic [NUM_POINTS-1:0] image_outputs,
  output logic run_monitor_flag,
  output logic scan_start,
  output logic [NUM_POINTS-1:0] output_pins,
  output logic step_transfer_grant,
  output logic step_output_enable,
  output logic [SCAN_W-1:0] scan_time_now,
  output logic [SCAN_W-1:0] scan_time_min,
  output logic [SCAN_W-1:0] scan_time_max
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_POINTS-1:0] pt_meta;
  logic [NUM_POINTS-1:0] pt_sync;
  logic [1:0] sw_meta;
  logic [1:0] sw_sync;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pt_meta <= OUT_OFF;
      pt_sync <= OUT_OFF;
      sw_meta <= 2'h0;
      sw_sync <= 2'h0;
    end
    else if (clk_en)
    begin
      pt_meta <= input_points;
      pt_sync <= pt_meta;
      sw_meta <= {mode_switch_run_pin, stop_switch_pin};
      sw_sync <= sw_meta;
    end
  end

  // ---------------------------------------------------------------
  // Run input selection, caught once after reset release
  // ---------------------------------------------------------------
  // Reset stands in for power cycling; later writes are ignored
  logic [SEL_W-1:0] run_sel;
  logic sel_captured;
  logic [SEL_W-1:0] next_run_sel;
  logic next_sel_captured;

  always_comb
  begin
    next_run_sel = run_sel;
    next_sel_captured = sel_captured;
    if (!sel_captured)
    begin
      next_run_sel = run_input_sel_cfg;
      next_sel_captured = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_sel <= RUN_SEL_RST;
      sel_captured <= 1'b0;
    end
    else if (clk_en)
    begin
      run_sel <= next_run_sel;
      sel_captured <= next_sel_captured;
    end
  end

  // ---------------------------------------------------------------
  // Request edge detection
  // ---------------------------------------------------------------
  logic prev_run_pt;
  logic prev_stop_sw;
  logic prev_mode_sw;
  logic prev_frc_run;
  logic prev_frc_stop;
  logic run_pt;
  logic frc_run;
  logic run_evt;
  logic stop_evt;

  assign run_pt = pt_sync[run_sel];
  assign frc_run = forced_run_mode_flag & forced_run_request_flag;
  // Pin and forced-flag requests are one-shots: a held button fires once; tool commands act while high
  assign run_evt = (run_pt & ~prev_run_pt)
    | (sw_sync[1] & ~prev_mode_sw)
    | tool_run_cmd
    | (frc_run & ~prev_frc_run);
  assign stop_evt = (sw_sync[0] & ~prev_stop_sw)
    | tool_stop_cmd
    | (forced_stop_request_flag & ~prev_frc_stop);

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_run_pt <= 1'b0;
      prev_stop_sw <= 1'b0;
      prev_mode_sw <= 1'b0;
      prev_frc_run <= 1'b0;
      prev_frc_stop <= 1'b0;
    end
    else if (clk_en)
    begin
      prev_run_pt <= run_pt;
      prev_stop_sw <= sw_sync[0];
      prev_mode_sw <= sw_sync[1];
      prev_frc_run <= frc_run;
      prev_frc_stop <= forced_stop_request_flag;
    end
  end

  // ---------------------------------------------------------------
  // Scan sequencer and mode
  // ---------------------------------------------------------------
  prsc_state_t state;
  prsc_state_t next_state;
  logic pend_run;
  logic pend_stop;
  logic [TICK_W-1:0] tick_cnt;
  logic [SCAN_W-1:0] ms_cnt;
  logic next_pend_run;
  logic next_pend_stop;
  logic [TICK_W-1:0] next_tick_cnt;
  logic [SCAN_W-1:0] next_ms_cnt;
  logic next_run;
  logic next_scan_start;
  logic [SCAN_W-1:0] next_now;
  logic [SCAN_W-1:0] next_min;
  logic [SCAN_W-1:0] next_max;
  logic boundary;

  always_comb
  begin
    next_state = state;
    next_run = run_monitor_flag;
    next_scan_start = 1'b0;
    next_now = scan_time_now;
    next_min = scan_time_min;
    next_max = scan_time_max;
    // Stop set wins over clear: a stop request in a boundary cycle counts
    next_pend_run = pend_run | run_evt;
    next_pend_stop = pend_stop | stop_evt;
    next_tick_cnt = tick_cnt + TICK_ONE;
    next_ms_cnt = ms_cnt;
    boundary = 1'b0;
    if (tick_cnt == TICK_W'(MS_CYCLES - 1))
    begin
      next_tick_cnt = TICK_ZERO;
      if (ms_cnt != SCAN_FULL)
      begin
        next_ms_cnt = ms_cnt + SCAN_ONE;
      end
    end
    unique case (state)
      PRSC_STOP:
      begin
        next_tick_cnt = TICK_ZERO;
        next_ms_cnt = SCAN_ZERO;
        if (next_pend_stop)
        begin
          next_pend_stop = 1'b0;
          next_pend_run = 1'b0;
        end
        else if (next_pend_run)
        begin
          next_pend_run = 1'b0;
          next_run = 1'b1;
          next_scan_start = 1'b1;
          next_state = PRSC_EXEC;
        end
      end
      PRSC_EXEC:
      begin
        if (scan_done)
        begin
          if (fixed_scan_enable_flag && ms_cnt < fixed_scan_time_register)
          begin
            next_state = PRSC_PAD;
          end
          else
          begin
            boundary = 1'b1;
          end
        end
      end
      PRSC_PAD:
      begin
        if (!fixed_scan_enable_flag || ms_cnt >= fixed_scan_time_register)
        begin
          boundary = 1'b1;
        end
      end
      default:
      begin
        next_state = PRSC_STOP;
        next_run = 1'b0;
      end
    endcase
    if (boundary)
    begin
      // Display holds execution plus idle padding
      next_now = ms_cnt;
      if (ms_cnt < scan_time_min)
      begin
        next_min = ms_cnt;
      end
      if (ms_cnt > scan_time_max)
      begin
        next_max = ms_cnt;
      end
      next_tick_cnt = TICK_ZERO;
      next_ms_cnt = SCAN_ZERO;
      next_pend_run = 1'b0;
      if (next_pend_stop)
      begin
        next_pend_stop = 1'b0;
        next_run = 1'b0;
        next_state = PRSC_STOP;
      end
      else
      begin
        next_scan_start = 1'b1;
        next_state = PRSC_EXEC;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= PRSC_STOP;
      run_monitor_flag <= 1'b0;
      scan_start <= 1'b0;
      pend_run <= 1'b0;
      pend_stop <= 1'b0;
      tick_cnt <= TICK_ZERO;
      ms_cnt <= SCAN_ZERO;
      scan_time_now <= SCAN_ZERO;
      scan_time_min <= SCAN_MIN_RST;
      scan_time_max <= SCAN_ZERO;
    end
    else if (clk_en)
    begin
      state <= next_state;
      run_monitor_flag <= next_run;
      scan_start <= next_scan_start;
      pend_run <= next_pend_run;
      pend_stop <= next_pend_stop;
      tick_cnt <= next_tick_cnt;
      ms_cnt <= next_ms_cnt;
      scan_time_now <= next_now;
      scan_time_min <= next_min;
      scan_time_max <= next_max;
    end
  end

  // ---------------------------------------------------------------
  // Output memory and step transfer gating
  // ---------------------------------------------------------------
  logic [NUM_POINTS-1:0] next_pins;
  logic next_grant;
  logic next_step_en;

  always_comb
  begin
    if (global_output_inhibit_flag)
    begin
      next_pins = OUT_OFF;
    end
    else if (run_monitor_flag)
    begin
      next_pins = image_outputs;
    end
    else if (output_hold_on_stop_flag)
    begin
      next_pins = output_pins;
    end
    else
    begin
      next_pins = OUT_OFF;
    end
    next_grant = run_monitor_flag & step_transfer_req & ~step_transfer_inhibit_flag;
    // Active step keeps driving its outputs
    next_step_en = run_monitor_flag;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      output_pins <= OUT_OFF;
      step_transfer_grant <= 1'b0;
      step_output_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      output_pins <= next_pins;
      step_transfer_grant <= next_grant;
      step_output_enable <= next_step_en;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_inhibit_clears_out: assert property (
    clk_en && global_output_inhibit_flag |=> output_pins == OUT_OFF)
    else $error("outputs not cleared under inhibit");
  a_hold_keeps_out: assert property (
    clk_en && !run_monitor_flag && output_hold_on_stop_flag && !global_output_inhibit_flag
    |=> output_pins == $past(output_pins))
    else $error("outputs not held in stop");
  a_stop_clears_out: assert property (
    clk_en && !run_monitor_flag && !output_hold_on_stop_flag |=> output_pins == OUT_OFF)
    else $error("outputs not off in stop");
  a_stop_has_priority: assert property (
    clk_en && state == PRSC_STOP && run_evt && stop_evt |=> !run_monitor_flag)
    else $error("run entered despite stop");
  a_run_from_stop: assert property (
    clk_en && state == PRSC_STOP && run_evt && !stop_evt && !pend_stop
    |=> run_monitor_flag && scan_start && state == PRSC_EXEC)
    else $error("run request not honoured");
  a_min_scan_pad: assert property (
    clk_en && state == PRSC_EXEC && scan_done && fixed_scan_enable_flag
    && ms_cnt < fixed_scan_time_register |=> state == PRSC_PAD && !scan_start)
    else $error("fixed scan not padded");
  a_no_midscan_stop: assert property (
    clk_en && state == PRSC_EXEC && !scan_done |=> run_monitor_flag)
    else $error("mode changed mid scan");
  a_step_blocked: assert property (
    clk_en && step_transfer_inhibit_flag |=> !step_transfer_grant)
    else $error("step transfer while inhibited");
  a_step_out_on: assert property (
    clk_en && run_monitor_flag |=> step_output_enable)
    else $error("step outputs stopped");
  a_sel_frozen: assert property (
    sel_captured |=> run_sel == $past(run_sel))
    else $error("run input changed after start");
  a_disp_incl_pad: assert property (
    clk_en && state == PRSC_PAD && ms_cnt >= fixed_scan_time_register
    |=> scan_time_now == $past(ms_cnt) && scan_start == run_monitor_flag)
    else $error("padded scan time not shown");

  c_run_then_stop: cover property (
    run_monitor_flag ##[1:20] !run_monitor_flag);
  c_pad_scan: cover property (state == PRSC_PAD ##1 scan_start);
  c_both_requests: cover property (run_evt && stop_evt);
  c_hold_stop: cover property (
    run_monitor_flag && output_hold_on_stop_flag ##1 !run_monitor_flag);

endmodule

// ==== core/prsc_pkg.sv ====
// Constants and types for the run/stop and scan supervision block
package prsc_pkg;
  // ---------------------------------------------------------------
  // Input points and run-input selection
  // ---------------------------------------------------------------
  localparam int NUM_POINTS = 16;
  localparam int SEL_W = 4;
  localparam logic [SEL_W-1:0] RUN_SEL_FIRST = 4'h0;
  localparam logic [SEL_W-1:0] RUN_SEL_LAST = 4'hF;
  localparam logic [SEL_W-1:0] RUN_SEL_RST = 4'h0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 24;
  localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;
  localparam logic [TICK_W-1:0] TICK_ONE = 24'h000001;
  // ---------------------------------------------------------------
  // Scan time in milliseconds
  // ---------------------------------------------------------------
  localparam int SCAN_W = 16;
  localparam logic [SCAN_W-1:0] SCAN_ZERO = 16'h0000;
  localparam logic [SCAN_W-1:0] SCAN_ONE = 16'h0001;
  localparam logic [SCAN_W-1:0] SCAN_FULL = 16'hFFFF;
  localparam logic [SCAN_W-1:0] SCAN_MIN_RST = 16'hFFFF;
  localparam logic [NUM_POINTS-1:0] OUT_OFF = 16'h0000;
  // ---------------------------------------------------------------
  // Scan sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PRSC_STOP = 2'b00,
    PRSC_EXEC = 2'b01,
    PRSC_PAD = 2'b10
  } prsc_state_t;
endpackage

// ==== verif/prsc_program_model.sv ====
// User program model: one done pulse per scan start
`timescale 1ns/1ps
module prsc_program_model
  import prsc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic scan_start,
  input wire logic [7:0] exec_len,
  output logic scan_done
);
  // ---------------------------------------------------------------
  // Execution counter
  // ---------------------------------------------------------------
  logic [7:0] count;
  logic busy;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count <= 8'h00;
      busy <= 1'b0;
      scan_done <= 1'b0;
    end
    else if (clk_en)
    begin
      // Program halts with the core while the clock enable is low
      scan_done <= 1'b0;
      if (scan_start) // Restart at step zero
      begin
        count <= 8'h01;
        busy <= 1'b1;
      end
      else if (busy && count >= exec_len)
      begin
        busy <= 1'b0;
        scan_done <= 1'b1;
      end
      else if (busy)
        count <= count + 8'h01;
    end
  end
endmodule

// ==== verif/test_prsc_ctrl.sv ====
// Self-checking bench for the run/stop and scan supervision block
`timescale 1ns/1ps
module test_prsc_ctrl;
  import prsc_pkg::*;
  logic clock = 0, rst_n = 0, stop_pin = 0, mode_pin = 0, t_run = 0, t_stop = 0;
  logic f_mode = 0, f_req = 0, f_stop = 0, hold = 0, inhibit = 0, fixed_en = 0;
  logic step_inh = 0, step_req = 0, scan_done, run, scan_start, grant, step_oe, en = 1;
  logic [NUM_POINTS-1:0] points = 16'h0000, image = 16'h0000, pins;
  logic [SEL_W-1:0] sel = RUN_SEL_LAST;
  logic [SCAN_W-1:0] fixed_ms = 16'h0002, t_now, t_min, t_max;
  logic [7:0] exec_len = 8'h03;
  int mismatches = 0, total_checks = 0;
  always #5 clock = ~clock;
  prsc_ctrl #(.MS_CYCLES(4)) u_prsc_ctrl (.clock(clock), .rst_n(rst_n), .clk_en(en),
    .input_points(points), .stop_switch_pin(stop_pin), .mode_switch_run_pin(mode_pin),
    .run_input_sel_cfg(sel), .tool_run_cmd(t_run), .tool_stop_cmd(t_stop),
    .forced_run_mode_flag(f_mode), .forced_run_request_flag(f_req),
    .forced_stop_request_flag(f_stop), .output_hold_on_stop_flag(hold),
    .global_output_inhibit_flag(inhibit), .fixed_scan_enable_flag(fixed_en),
    .fixed_scan_time_register(fixed_ms), .step_transfer_inhibit_flag(step_inh),
    .step_transfer_req(step_req), .scan_done(scan_done), .image_outputs(image),
    .run_monitor_flag(run), .scan_start(scan_start), .output_pins(pins),
    .step_transfer_grant(grant), .step_output_enable(step_oe), .scan_time_now(t_now),
    .scan_time_min(t_min), .scan_time_max(t_max));
  prsc_program_model u_prsc_program_model (.clock(clock), .rst_n(rst_n), .clk_en(en),
    .scan_start(scan_start), .exec_len(exec_len), .scan_done(scan_done));
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Bounded wait, then compare the mode
  task automatic wait_mode(input logic want);
    // Long enough for a stop that waits out a twenty ms padded scan
    for (int n = 0; n < 200 && run !== want; n++) tick(1);
    chk("run_monitor_flag", {15'h0000, want}, {15'h0000, run});
  endtask
  task automatic wait_start();
    for (int n = 0; n < 200 && scan_start !== 1'b1; n++) tick(1);
  endtask
  task automatic do_reset();
    rst_n = 0;
    tick(8);
    rst_n = 1;
    tick(3);
  endtask
  task automatic tool(input logic go);
    if (go)
      t_run = 1;
    else
      t_stop = 1;
    tick(1);
    // Lower only the strobe raised, so back-to-back calls never glitch
    if (go)
      t_run = 0;
    else
      t_stop = 0;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_tool();
    chk("scan_time_min", SCAN_MIN_RST, t_min);
    tool(1);
    chk("run_monitor_flag", 16'h0001, {15'h0000, run});
    exec_len = 8'h14;
    wait_start();
    tool(0);
    tick(2);
    chk("mid scan mode", 16'h0001, {15'h0000, run});
    wait_mode(0);
    exec_len = 8'h03;
  endtask
  task automatic t_pins();
    points[15] = 1; tick(1); points[15] = 0;
    wait_mode(1);
    stop_pin = 1; tick(1); stop_pin = 0;
    wait_mode(0);
    points[15] = 1; stop_pin = 1; tick(1); points[15] = 0; stop_pin = 0;
    tick(3);
    chk("run_monitor_flag", 16'h0000, {15'h0000, run});
    sel = RUN_SEL_FIRST;
    points[0] = 1; tick(1); points[0] = 0;
    tick(20);
    wait_mode(0);
    do_reset();
    points[0] = 1; tick(1); points[0] = 0;
    wait_mode(1);
    tool(0);
    wait_mode(0);
  endtask
  task automatic t_switch();
    mode_pin = 1;
    wait_mode(1);
    stop_pin = 1; tick(1); stop_pin = 0;
    wait_mode(0);
    tool(1);
    tool(0);
    wait_mode(0);
    tool(1);
    f_stop = 1;
    wait_mode(0);
    f_stop = 0;
    mode_pin = 0;
    f_mode = 1; f_req = 1;
    wait_mode(1);
    f_stop = 1;
    wait_mode(0);
    f_stop = 0; f_mode = 0; f_req = 0;
  endtask
  task automatic t_outputs();
    image = 16'hA5C3;
    tool(1);
    tick(3);
    chk("output_pins", 16'hA5C3, pins);
    inhibit = 1;
    tick(2);
    chk("output_pins", OUT_OFF, pins);
    chk("run_monitor_flag", 16'h0001, {15'h0000, run});
    inhibit = 0; hold = 1;
    tool(0);
    wait_mode(0);
    tick(2);
    chk("output_pins", 16'hA5C3, pins);
    hold = 0;
    tool(1);
    tick(3);
    tool(0);
    wait_mode(0);
    tick(2);
    chk("output_pins", OUT_OFF, pins);
  endtask
  task automatic t_step();
    tool(1);
    step_req = 1; step_inh = 1;
    tick(2);
    chk("step_transfer_grant", 16'h0000, {15'h0000, grant});
    chk("step_output_enable", 16'h0001, {15'h0000, step_oe});
    en = 0;
    step_inh = 0;
    tick(3);
    chk("step_transfer_grant frozen", 16'h0000, {15'h0000, grant});
    en = 1;
    tick(2);
    chk("step_transfer_grant", 16'h0001, {15'h0000, grant});
    step_req = 0;
    tool(0);
    wait_mode(0);
  endtask
  // Fixed scan of 2 ms at 4 cycles per ms
  task automatic t_fixed();
    int cnt;
    fixed_en = 1; exec_len = 8'h01;
    tool(1);
    wait_start();
    tick(1);
    for (cnt = 1; cnt < 200 && scan_start !== 1'b1; cnt++) tick(1);
    chk("scan period ok", 16'h0001, {15'h0000, cnt >= 8 && cnt < 200});
    chk("scan_time_now", 16'h0002, t_now);
    fixed_ms = 16'h0014; // Key input filter needs twenty ms
    wait_start(); tick(1); wait_start();
    tick(1);
    wait_start();
    chk("scan_time_now", 16'h0014, t_now);
    chk("scan_time_max", 16'h0014, t_max);
    // Plain scans since reset last five cycles, one whole ms
    chk("scan_time_min", 16'h0001, t_min);
    tool(0);
    wait_mode(0);
    fixed_en = 0;
  endtask
  // ---------------------------------------------------------------
  // Sequence and verdict
  // ---------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    #200000;
    mismatches++;
    conclude();
  end
  initial
  begin
    do_reset();
    t_tool();
    t_pins();
    t_switch();
    t_outputs();
    t_step();
    t_fixed();
    conclude();
  end
endmodule
